// *** tmic_pkg.sv ***
package tmic_pkg;
	localparam logic [11:0] TMIC_OFF_ROUTE_A = 12'h000;
	localparam logic [11:0] TMIC_OFF_ROUTE_B = 12'h004;
	localparam logic [11:0] TMIC_OFF_TRG_MODE = 12'h008;
	localparam logic [11:0] TMIC_OFF_CH_MODE = 12'h00c;
	localparam logic [11:0] TMIC_OFF_STATUS = 12'h010;
	localparam logic [11:0] TMIC_OFF_MASK = 12'h014;
	localparam int TMIC_CNT_LO = 10;
	localparam int TMIC_NBITS = 4;
	localparam int TMIC_ACT_LSB = 4;
	localparam int TMIC_SWAP_BIT = 7;
	localparam logic [7:0] TMIC_ROUTE_RST = 8'h00;
	localparam logic [7:0] TMIC_TRG_RST = 8'h00;
	localparam logic [7:0] TMIC_CHM_RST = 8'h00;
	localparam logic [7:0] TMIC_STAT_RST = 8'h00;
	localparam logic [7:0] TMIC_MASK_RST = 8'h00;
	localparam logic [2:0] TMIC_PWM_FIELD = 3'h7;

	typedef struct packed {
		logic [3:0] act_en;
		logic [3:0] irq_en;
	} tmic_route_t;

	typedef struct packed {
		logic [2:0] pwm_sel;
		logic [2:0] ioctl_ignore;
		logic [2:0] gr_d_writable;
	} tmic_chmode_t;

	typedef struct packed {
		logic start;
		logic stop;
	} tmic_oneshot_t;
endpackage : tmic_pkg

// *** tmic_ctrl.sv ***
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - rise of counter bit 10 pulses converter activation when enabled; A->conv0, B->conv1.
// - enabled rise of counter bits 10..13 sets interval flag and raises interrupt; the irq output also needs the irq_mask bit set.
// - bit 4 activation enable for bit 10; bits 3..0 irq enables 13..10; reset 0.
// - swap bit 0: counter B compare starts one-shot, counter A match terminates.
// - swap bit 1: roles exchanged between the two compare matches.
// - trigger routing only matters when channels 1 and 8 work together.
// - trigger mode register cleared on reset and on either standby.
// - channel mode register cleared on reset and on either standby.
// - reserved bits read zero; software writes zero there.
// - channel mode bits 2,1,0 select PWM for channels 5,4,3.
// - PWM channel drives pins A-C, register D period, A-C duty.
// - in PWM, I/O control settings ignored and registers A-D writable.
// - bits 7,6,5 enable converter activation for counter bits 13,12,11.
module tmic_ctrl
	import tmic_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// standby entry (either kind)
	input wire logic hw_standby,
	input wire logic sw_standby,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// free counter zero bits 13..10
	input wire logic [3:0] free_counter_zero_hi,
	// channel 1 compare matches and channel 8 link
	input wire logic ch1_counter_b_match_ocr,
	input wire logic ch1_counter_a_match_gr,
	input wire logic ch1_ch8_linked,
	// outputs
	output logic conv0_act,
	output logic conv1_act,
	output logic [1:0] interval_irq_hi,
	output logic irq,
	output tmic_pkg::tmic_oneshot_t ch8_oneshot,
	output tmic_pkg::tmic_chmode_t ch_mode
);
	import tmic_pkg::*;

	tmic_route_t interval_route_a;
	tmic_route_t interval_route_b;
	logic trigger_swap_bit;
	logic [2:0] channel_mode_select;
	logic [1:0] interval_flag_hi;
	logic [1:0] irq_mask;
	logic [3:0] prev_bits;
	logic [3:0] rise;
	logic standby;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [1:0] flag_set;
	logic [1:0] flag_clr;
	logic [31:0] next_rdata;

	assign standby = hw_standby | sw_standby;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	// history of the counter bits for edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prev_bits <= 4'h0;
		else
			prev_bits <= free_counter_zero_hi;
	end
	assign rise = free_counter_zero_hi & ~prev_bits;

	// route registers, bit 4 = bit 10 activation, 3..0 irq enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			interval_route_a <= TMIC_ROUTE_RST;
			interval_route_b <= TMIC_ROUTE_RST;
		end
		else if (standby)
		begin
			interval_route_a <= TMIC_ROUTE_RST;
			interval_route_b <= TMIC_ROUTE_RST;
		end
		else if (wr_en)
		begin
			if (paddr == TMIC_OFF_ROUTE_A)
				interval_route_a <= pwdata[7:0];
			if (paddr == TMIC_OFF_ROUTE_B)
				interval_route_b <= pwdata[7:0];
		end
	end

	// trigger mode: only the swap bit is stored, the rest is reserved
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trigger_swap_bit <= TMIC_TRG_RST[TMIC_SWAP_BIT];
		else if (standby)
			trigger_swap_bit <= TMIC_TRG_RST[TMIC_SWAP_BIT];
		else if (wr_en && paddr == TMIC_OFF_TRG_MODE)
			trigger_swap_bit <= pwdata[TMIC_SWAP_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			channel_mode_select <= TMIC_CHM_RST[2:0];
		else if (standby)
			channel_mode_select <= TMIC_CHM_RST[2:0];
		else if (wr_en && paddr == TMIC_OFF_CH_MODE)
			channel_mode_select <= pwdata[2:0] & TMIC_PWM_FIELD;
	end

	// index 0 is route a, index 1 route b
	assign flag_set[0] = |(rise & interval_route_a.irq_en);
	assign flag_set[1] = |(rise & interval_route_b.irq_en);
	assign flag_clr = (wr_en && paddr == TMIC_OFF_STATUS) ? pwdata[1:0] : 2'h0;

	// sticky flags; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			interval_flag_hi <= TMIC_STAT_RST[1:0];
		else
			interval_flag_hi <= (interval_flag_hi & ~flag_clr) | flag_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask <= TMIC_MASK_RST[1:0];
		else if (wr_en && paddr == TMIC_OFF_MASK)
			irq_mask <= pwdata[1:0];
	end

	// converter activation pulses and interrupt lines
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv0_act <= 1'b0;
			conv1_act <= 1'b0;
			interval_irq_hi <= 2'h0;
			irq <= 1'b0;
		end
		else
		begin
			conv0_act <= |(rise & interval_route_a.act_en);
			conv1_act <= |(rise & interval_route_b.act_en);
			interval_irq_hi <= flag_set;
			irq <= |(((interval_flag_hi & ~flag_clr) | flag_set) & irq_mask);
		end
	end

	// one-shot trigger routing, only active with channels linked
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ch8_oneshot <= '0;
		else if (!ch1_ch8_linked)
			ch8_oneshot <= '0;
		else if (!trigger_swap_bit)
		begin
			ch8_oneshot.start <= ch1_counter_b_match_ocr;
			ch8_oneshot.stop <= ch1_counter_a_match_gr;
		end
		else
		begin
			ch8_oneshot.start <= ch1_counter_a_match_gr;
			ch8_oneshot.stop <= ch1_counter_b_match_ocr;
		end
	end

	// pwm controls: pins a-c as pwm, d as period, ioctl ignored, gr a-d writable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ch_mode <= '0;
		else
		begin
			ch_mode.pwm_sel <= channel_mode_select;
			ch_mode.ioctl_ignore <= channel_mode_select;
			ch_mode.gr_d_writable <= channel_mode_select;
		end
	end

	assign addr_ok = (paddr == TMIC_OFF_ROUTE_A) || (paddr == TMIC_OFF_ROUTE_B) ||
		(paddr == TMIC_OFF_TRG_MODE) || (paddr == TMIC_OFF_CH_MODE) ||
		(paddr == TMIC_OFF_STATUS) || (paddr == TMIC_OFF_MASK);

	always_comb
	begin
		next_rdata = 32'h0;
		unique case (paddr)
			TMIC_OFF_ROUTE_A: next_rdata[7:0] = interval_route_a;
			TMIC_OFF_ROUTE_B: next_rdata[7:0] = interval_route_b;
			TMIC_OFF_TRG_MODE: next_rdata[TMIC_SWAP_BIT] = trigger_swap_bit;
			TMIC_OFF_CH_MODE: next_rdata[2:0] = channel_mode_select;
			TMIC_OFF_STATUS: next_rdata[1:0] = interval_flag_hi;
			TMIC_OFF_MASK: next_rdata[1:0] = irq_mask;
			default: next_rdata = 32'h0;
		endcase
	end

	// read data captured in setup, answer one cycle later with pready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			if (rd_en)
				prdata <= next_rdata;
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
		end
	end
endmodule : tmic_ctrl

// *** tmic_ctrl_assertions.sv ***
`timescale 1ns/1ps
module tmic_ctrl_assertions
	import tmic_pkg::*;
(
	// clock, reset, standby
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hw_standby,
	input wire logic sw_standby,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// events and modes
	input wire logic [3:0] free_counter_zero_hi,
	input wire logic ch1_ch8_linked,
	input wire logic conv0_act,
	input wire logic conv1_act,
	input wire logic [1:0] interval_irq_hi,
	input wire tmic_pkg::tmic_oneshot_t ch8_oneshot,
	input wire tmic_pkg::tmic_chmode_t ch_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a pulse at c+1 needs a bit low at c-1 and high at c
	sequence hi_rose;
		($past(free_counter_zero_hi) & ~$past(free_counter_zero_hi, 2)) != 4'h0;
	endsequence
	sequence rd_s(a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	a_conv0_cause: assert property (conv0_act |-> hi_rose)
		else $error("conv0 pulse without counter rise");
	a_conv1_cause: assert property (conv1_act |-> hi_rose)
		else $error("conv1 pulse without counter rise");
	a_flag_cause: assert property (interval_irq_hi != 2'h0 |-> hi_rose)
		else $error("flag event without counter rise");
	// the mode register clears on the first edge, its output copy one edge later
	a_standby_clr: assert property ((hw_standby || sw_standby) |-> ##2 ch_mode.pwm_sel == 3'h0)
		else $error("channel mode kept in standby");
	a_mode_ioctl: assert property (ch_mode.ioctl_ignore == ch_mode.pwm_sel)
		else $error("io control ignore differs from pwm select");
	a_shot_unlinked: assert property (!ch1_ch8_linked |=> ch8_oneshot == 2'h0)
		else $error("one-shot trigger while unlinked");
	a_trg_rsv: assert property (rd_s(TMIC_OFF_TRG_MODE) |=> pready && prdata[6:0] == 7'h0)
		else $error("trigger mode reserved bits not zero");
	a_chm_rsv: assert property (rd_s(TMIC_OFF_CH_MODE) |=> pready && prdata[7:3] == 5'h0)
		else $error("channel mode reserved bits not zero");
endmodule : tmic_ctrl_assertions
bind tmic_ctrl tmic_ctrl_assertions tmic_ctrl_assertions_i (.*);

// *** tmic_conv_sink.sv ***
`timescale 1ns/1ps
module tmic_conv_sink
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// activation pulses, conversions started
	input wire logic conv0_act,
	input wire logic conv1_act,
	output int n0,
	output int n1
);
	// one conversion per pulse, so a stretched pulse shows up as extra counts
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			n0 <= 0;
			n1 <= 0;
		end
		else
		begin
			n0 <= n0 + int'(conv0_act);
			n1 <= n1 + int'(conv1_act);
		end
endmodule : tmic_conv_sink

// *** tmic_ctrl_test.sv ***
`timescale 1ns/1ps
module tmic_ctrl_test;
	import tmic_pkg::*;
	logic pclk = 0, presetn = 0, hw_standby = 0, sw_standby = 0, pready, pslverr;
	logic psel = 0, penable = 0, pwrite = 0, mb = 0, ma = 0, lnk = 0;
	logic conv0_act, conv1_act, irq;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r, q[$];
	logic [3:0] hi = 0;
	logic [2:0] v;
	logic [1:0] interval_irq_hi;
	tmic_oneshot_t ch8_oneshot;
	tmic_chmode_t ch_mode;
	int errors = 0, n_tests = 0, n0, n1, seed = 32'h6409;
	initial forever #20 pclk = ~pclk;
	tmic_ctrl tmic_ctrl_i (.free_counter_zero_hi(hi), .ch1_counter_b_match_ocr(mb),
		.ch1_counter_a_match_gr(ma), .ch1_ch8_linked(lnk), .*);
	tmic_conv_sink tmic_conv_sink_i (.*);
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (!pready && n < 16);
		if (!pready)
		begin
			errors++;
			tally_and_finish();
		end
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		apb(0, a, 0);
	endtask : rd
	task automatic ev(input logic [3:0] h, input logic b, a, l);
		@(posedge pclk);
		{hi, mb, ma, lnk} <= {h, b, a, l};
		@(posedge pclk);
		@(negedge pclk);
	endtask : ev
	always @(posedge pclk)
		if (psel && penable && pready)
		begin
			chk("pslverr", pslverr, paddr > TMIC_OFF_MASK);
			if (!pwrite)
				chk("prdata", prdata, q.pop_front());
		end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 7; i++)
			rd(12'(i * 4), 0);
		r = $random(seed);
		apb(1, TMIC_OFF_ROUTE_B, r & 32'hff);
		rd(TMIC_OFF_ROUTE_B, r & 32'hff);
		$display("registers done");
		apb(1, TMIC_OFF_ROUTE_B, 0);
		apb(1, TMIC_OFF_MASK, 3);
		for (int k = 0; k < 4; k++)
		begin
			apb(1, TMIC_OFF_ROUTE_A, 32'h10 << k | 32'h1 << k);
			ev(4'h1 << k, 0, 0, 0);
			chk("conv0", conv0_act, 1);
			chk("flag", interval_irq_hi, 1);
			chk("irq", irq, 1);
			apb(1, TMIC_OFF_STATUS, 1);
			rd(TMIC_OFF_STATUS, 0);
		end
		apb(1, TMIC_OFF_MASK, 0);
		apb(1, TMIC_OFF_ROUTE_A, 0);
		apb(1, TMIC_OFF_ROUTE_B, 32'h11);
		ev(4'h1, 0, 0, 0);
		chk("conv0_off", conv0_act, 0);
		chk("conv1", conv1_act, 1);
		chk("flag_b", interval_irq_hi, 2);
		chk("irq_masked", irq, 0);
		rd(TMIC_OFF_STATUS, 2);
		chk("adc", {n0[15:0], n1[15:0]}, 32'h40001);
		$display("interval events done");
		for (int s = 0; s < 2; s++)
		begin
			apb(1, TMIC_OFF_TRG_MODE, s << 7);
			rd(TMIC_OFF_TRG_MODE, s << 7);
			ev(4'h0, 1, 0, 1);
			chk("start", ch8_oneshot, {~s[0], s[0]});
			ev(4'h0, 0, 1, 1);
			chk("stop", ch8_oneshot, {s[0], ~s[0]});
		end
		ev(4'h0, 1, 1, 0);
		chk("unlinked", ch8_oneshot, 0);
		$display("trigger modes done");
		for (int m = 0; m < 2; m++)
		begin
			v = m ? 3'h2 : 3'h5;
			apb(1, TMIC_OFF_TRG_MODE, 32'h80);
			apb(1, TMIC_OFF_CH_MODE, v);
			rd(TMIC_OFF_CH_MODE, v);
			chk("pwm", ch_mode, {3{v}});
			{hw_standby, sw_standby} <= 2'(1 << m);
			repeat (2) @(posedge pclk);
			{hw_standby, sw_standby} <= 2'h0;
			rd(TMIC_OFF_TRG_MODE, 0);
			rd(TMIC_OFF_CH_MODE, 0);
		end
		$display("channel modes done");
		tally_and_finish();
	end
endmodule : tmic_ctrl_test
